// ---- hdl/sequencer_consts.vh ----
// constants for the multi-position sequencer
`ifndef SEQUENCER_CONSTS_VH
`define SEQUENCER_CONSTS_VH
// register offsets on the plain register port
`define REG_RUN_MODE 4'h0
`define REG_PROFILE_COUNT 4'h1
`define REG_RESUME_METHOD 4'h2
`define REG_POS_SOURCE 4'h3
`define REG_CONTROL 4'h4
`define REG_STATUS 4'h5
`define REG_PROFILE_BASE 4'h8
`define REG_PROFILE_INDEX 4'h8
`define REG_PROFILE_DISP 4'h9
`define REG_PROFILE_SPEED 4'hA
`define REG_PROFILE_ACCEL 4'hB
// reset values
`define RUN_MODE_RESET 2'h1
`define PROFILE_COUNT_RESET 5'h01
`define RESUME_METHOD_RESET 1'h0
`define POS_SOURCE_RESET 2'h0
// encodings
`define MODE_SINGLE 2'h0
`define MODE_CYCLIC 2'h1
`define MODE_SELECT 2'h2
`define MODE_SEQUENTIAL 2'h3
`define POS_SOURCE_MULTI 2'h2
`define PROFILE_COUNT_MIN 5'h01
`define PROFILE_COUNT_MAX 5'h10
// control register field positions
`define CTRL_POS_MODE_BIT 0
`define CTRL_FLY_BIT 1
`define CTRL_START_BIT 2
// profile word layout: disp 32, speed 16, accel 16
`define PROFILE_WIDTH 64
`endif

// ---- hdl/profile_store.v ----
// sixteen-entry profile memory with registered read data
`timescale 1ns/100ps
module profile_store (
   // clock
   input wire sys_clk,
   // write side
   input wire writeEn,
   input wire [3:0] writeAddr,
   input wire [63:0] writeData,
   // read side
   input wire [3:0] readAddr,
   output reg [63:0] readData
);
   reg [63:0] mem [0:15]; // one word per profile

   // write port; contents need no reset, software loads them
   always @(posedge sys_clk) begin
      if (writeEn) begin
         mem[writeAddr] <= writeData;
      end
      readData <= mem[readAddr];
   end
endmodule // profile_store

// ---- hdl/input_sync.v ----
// two-flop synchroniser bank for the pin inputs
`timescale 1ns/100ps
module input_sync (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // raw and synchronised levels
   input wire [4:0] rawIn,
   output reg [4:0] syncOut
);
   reg [4:0] stage1; // first stage, read only by syncOut

   // two flip-flops per bit
   always @(posedge sys_clk) begin
      if (rst) begin
         stage1 <= 5'h00;
         syncOut <= 5'h00;
      end else begin
         stage1 <= rawIn;
         syncOut <= stage1;
      end
   end
endmodule // input_sync

// ---- hdl/multi_position_sequencer.v ----
// multi-position sequencer: profile stepping, select inputs, pause and resume
//
// Contract
// - run mode 0..3, reset to cyclic
// - act only in position mode, source 2
// - profile count 1..16, default 1
// - non-select modes step profiles ascending
// - mode 2 profile from four select inputs
// - profile number equals select code plus one
// - select bit is one when input active
// - mode change or on-fly change pauses running
// - enable input falling pauses running
// - resume method 0 continues after interrupted
// - resume method 1 restarts at profile one
// - pause discards remaining profile distance
// - mode 2 resume uses select inputs
`timescale 1ns/100ps
`include "sequencer_consts.vh"
module multi_position_sequencer (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // register port
   input wire [3:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [31:0] regRdData,
   // pins: select bits and sequencer enable, asynchronous
   input wire profileSelectBit0,
   input wire profileSelectBit1,
   input wire profileSelectBit2,
   input wire profileSelectBit3,
   input wire sequencerEnableInput,
   // profile handshake with the motion generator
   input wire profileDone,
   output reg profileStart,
   output reg discardRemaining,
   output reg [31:0] profileDisp,
   output reg [15:0] profileSpeed,
   output reg [15:0] profileAccel,
   // status
   output reg running,
   output reg paused,
   output reg [4:0] activeProfile
);
   // sequencer states
   // fetch and load are fixed one-cycle steps: the store answers one
   // cycle after its address, and the words are latched on the edge leaving load,
   // so every profile start lands two edges after its decision edge
   // pause is only taken in run; fetch and load are short enough that a
   // cause seen there is simply acted on once run is reached
   localparam IDLE = 3'h0;
   localparam FETCH = 3'h1;
   localparam LOAD = 3'h2;
   localparam RUN = 3'h3;
   localparam PAUSE = 3'h4;

   // settings
   reg [1:0] runMode; // sequencer_run_mode_setting
   reg [4:0] profileCount; // profile_count_setting
   reg resumeMethod; // resume_method_setting
   reg [1:0] posSource; // main_position_source_setting
   reg posMode; // drive is in position control
   reg flyEnable; // position change-on-the-fly enabled
   reg [31:0] stageDisp; // staging for profile writes
   reg [15:0] stageSpeed;
   reg [15:0] stageAccel;
   // state
   reg [2:0] state;
   reg [2:0] next_state;
   reg [4:0] profileNum; // 1-based profile in progress
   reg [4:0] next_profileNum;
   // the enable pin is judged by level, not by edge: a drop that arrives
   // in fetch or load would leave no edge behind for run to see, and the
   // move would carry on with the enable gone
   // memory and synchronised pins
   wire [4:0] pinSync;
   wire [63:0] memRead;
   wire memWrite;
   wire [4:0] selectedProfile;
   wire seqActive;
   wire pauseEvent;
   wire stopped;

   // keeps a written count within 1..16
   function [4:0] clampCount;
      input [4:0] raw;
      begin
         if (raw < `PROFILE_COUNT_MIN) begin
            clampCount = `PROFILE_COUNT_MIN;
         end else if (raw > `PROFILE_COUNT_MAX) begin
            clampCount = `PROFILE_COUNT_MAX;
         end else begin
            clampCount = raw;
         end
      end
   endfunction

   // profile after the given one, wrapping to profile one past the count; used in the non-select modes
   function [4:0] nextAfter;
      input [4:0] cur;
      input [4:0] count;
      begin
         if (cur >= count) begin
            nextAfter = 5'h01;
         end else begin
            nextAfter = cur + 5'h01;
         end
      end
   endfunction

   input_sync pinSyncer (
      .sys_clk(sys_clk),
      .rst(rst),
      .rawIn({sequencerEnableInput, profileSelectBit3, profileSelectBit2,
              profileSelectBit1, profileSelectBit0}),
      .syncOut(pinSync)
   );

   // profile words are written from the staging regs on a write to index
   assign memWrite = regWrite && (regAddr == `REG_PROFILE_INDEX);

   // the read address follows next_profileNum, so the word for the next
   // profile is already on memRead in the fetch cycle; profile 16 wraps to
   // address 15 through the 4-bit subtraction
   profile_store store (
      .sys_clk(sys_clk),
      .writeEn(memWrite),
      .writeAddr(regWrData[3:0]),
      .writeData({stageDisp, stageSpeed, stageAccel}),
      .readAddr(next_profileNum[3:0] - 4'h1),
      .readData(memRead)
   );

   // select bit is one for an active input, code plus one
   assign selectedProfile = {1'b0, pinSync[3:0]} + 5'h01;
   // sequencer only acts in position mode with multi source
   assign seqActive = posMode && (posSource == `POS_SOURCE_MULTI);
   // pause causes: mode leaves, on-fly on, enable active to inactive
   // start and resume both demand the enable high, so a low level while
   // running can only mean the enable has gone inactive since
   assign pauseEvent = !seqActive || flyEnable || !pinSync[4];
   assign stopped = (state == IDLE) || (state == PAUSE);

   // register writes; run mode, count and resume method gated while running
   always @(posedge sys_clk) begin
      if (rst) begin
         runMode <= `RUN_MODE_RESET;
         profileCount <= `PROFILE_COUNT_RESET;
         resumeMethod <= `RESUME_METHOD_RESET;
         posSource <= `POS_SOURCE_RESET;
         posMode <= 1'b0;
         flyEnable <= 1'b0;
         stageDisp <= 32'h00000000;
         stageSpeed <= 16'h0000;
         stageAccel <= 16'h0000;
      end else if (regWrite) begin
         case (regAddr)
            `REG_RUN_MODE: begin
               if (stopped) begin
                  runMode <= regWrData[1:0];
               end
            end
            `REG_PROFILE_COUNT: begin
               if (stopped) begin
                  profileCount <= clampCount(regWrData[4:0]);
               end
            end
            `REG_RESUME_METHOD: begin
               if (stopped) begin
                  resumeMethod <= regWrData[0];
               end
            end
            `REG_POS_SOURCE: posSource <= regWrData[1:0];
            `REG_CONTROL: begin
               posMode <= regWrData[`CTRL_POS_MODE_BIT];
               flyEnable <= regWrData[`CTRL_FLY_BIT];
            end
            `REG_PROFILE_DISP: stageDisp <= regWrData;
            `REG_PROFILE_SPEED: stageSpeed <= regWrData[15:0];
            `REG_PROFILE_ACCEL: stageAccel <= regWrData[15:0];
            default: begin
               // status, index or unmapped; ignored here, an index write acts through memWrite
            end
         endcase
      end
   end

   // register reads, data in the next cycle; unmapped reads zero
   always @(posedge sys_clk) begin
      if (rst) begin
         regRdData <= 32'h00000000;
      end else if (regRead) begin
         case (regAddr)
            `REG_RUN_MODE: regRdData <= {30'h0, runMode};
            `REG_PROFILE_COUNT: regRdData <= {27'h0, profileCount};
            `REG_RESUME_METHOD: regRdData <= {31'h0, resumeMethod};
            `REG_POS_SOURCE: regRdData <= {30'h0, posSource};
            `REG_CONTROL: regRdData <= {30'h0, flyEnable, posMode};
            `REG_STATUS: regRdData <= {19'h0, pinSync, profileNum, state};
            default: regRdData <= 32'h00000000;
         endcase
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   // next-state logic
   always @* begin
      next_state = state;
      next_profileNum = profileNum;
      case (state)
         IDLE: begin
            // start on control write with start bit, when allowed
            if (regWrite && regAddr == `REG_CONTROL && regWrData[`CTRL_START_BIT]
                && seqActive && !flyEnable && pinSync[4]) begin
               next_state = FETCH;
               if (runMode == `MODE_SELECT) begin
                  next_profileNum = selectedProfile;
               end else begin
                  next_profileNum = 5'h01;
               end
            end
         end
         FETCH: next_state = LOAD; // memory read latency
         LOAD: next_state = RUN;
         RUN: begin
            if (pauseEvent) begin
               next_state = PAUSE;
               // remember where method 0 would carry on; method 1 and the
               // select mode are settled at resume, since both settings may
               // still be rewritten while paused
               if (runMode == `MODE_SELECT) begin
                  next_profileNum = profileNum; // refreshed from pins on resume
               end else begin
                  next_profileNum = nextAfter(profileNum, profileCount);
               end
            end else if (profileDone) begin
               if (runMode == `MODE_SELECT) begin
                  // host picks the next one through the select pins
                  next_state = FETCH;
                  next_profileNum = selectedProfile;
               end else if (runMode == `MODE_SINGLE && profileNum >= profileCount) begin
                  next_state = IDLE; // single cycle ends
               end else begin
                  next_state = FETCH;
                  next_profileNum = nextAfter(profileNum, profileCount);
               end
            end
         end
         PAUSE: begin
            // resume once conditions are restored
            if (seqActive && !flyEnable && pinSync[4]) begin
               next_state = FETCH;
               if (runMode == `MODE_SELECT) begin
                  next_profileNum = selectedProfile;
               end else if (resumeMethod) begin
                  next_profileNum = 5'h01;
               end
               // otherwise the profile after the interrupted one stands
            end
         end
         default: next_state = IDLE;
      endcase
   end

   // state registers and outputs
   always @(posedge sys_clk) begin
      if (rst) begin
         state <= IDLE;
         profileNum <= 5'h01;
         profileStart <= 1'b0;
         discardRemaining <= 1'b0;
         profileDisp <= 32'h00000000;
         profileSpeed <= 16'h0000;
         profileAccel <= 16'h0000;
         running <= 1'b0;
         paused <= 1'b0;
         activeProfile <= 5'h00;
      end else begin
         state <= next_state;
         profileNum <= next_profileNum;
         // profile words latched one cycle after the memory read
         profileStart <= (state == LOAD);
         if (state == LOAD) begin
            profileDisp <= memRead[63:32];
            profileSpeed <= memRead[31:16];
            profileAccel <= memRead[15:0];
            activeProfile <= profileNum;
         end
         // leftover distance of the current profile is dropped
         discardRemaining <= (state == RUN) && (next_state == PAUSE);
         running <= (next_state == FETCH) || (next_state == LOAD) || (next_state == RUN);
         paused <= (next_state == PAUSE);
      end
   end
endmodule // multi_position_sequencer

// ---- verification/multi_position_sequencer_props.sv ----
// concurrent checks on the sequencer top-level ports
`timescale 1ns/100ps
module multi_position_sequencer_props (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // register port
   input wire regRead,
   input wire [31:0] regRdData,
   // pins and handshake
   input wire sequencerEnableInput,
   input wire profileDone,
   input wire profileStart,
   input wire discardRemaining,
   // status
   input wire running,
   input wire paused,
   input wire [4:0] activeProfile
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // fetch and load cycles, nothing issued yet
   sequence s_prep;
      !profileStart ##1 !profileStart;
   endsequence
   // full issue: prep then the load pulse
   sequence s_issue;
      s_prep ##1 profileStart;
   endsequence
   property p_rd_idle;
      !regRead |=> regRdData == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_first;
      $rose(running) |-> s_issue;
   endproperty
   a_first: assert property (p_first) else $error("first profile late");
   // last profile in single mode stops instead of issuing
   property p_done_next;
      profileDone && running && !paused && !profileStart |-> ##1 s_prep ##1
         (profileStart || !running);
   endproperty
   a_done_next: assert property (p_done_next) else $error("next profile late");
   // enable pin passes the synchroniser first
   property p_pause_en;
      running && !paused && $fell(sequencerEnableInput) |-> ##[1:4] discardRemaining;
   endproperty
   a_pause_en: assert property (p_pause_en) else $error("no pause on enable");
   property p_disc_paused;
      discardRemaining |-> paused;
   endproperty
   a_disc_paused: assert property (p_disc_paused) else $error("discard not paused");
   property p_start_pulse;
      profileStart |=> !profileStart;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
   property p_range;
      profileStart |-> activeProfile >= 5'h01 && activeProfile <= 5'h10;
   endproperty
   a_range: assert property (p_range) else $error("profile out of range");
   property p_stopped;
      !running |-> !profileStart;
   endproperty
   a_stopped: assert property (p_stopped) else $error("start while stopped");
endmodule // multi_position_sequencer_props
bind multi_position_sequencer multi_position_sequencer_props u_props (.sys_clk, .rst,
   .regRead, .regRdData, .sequencerEnableInput, .profileDone, .profileStart,
   .discardRemaining, .running, .paused, .activeProfile);

// ---- verification/select_host.sv ----
// host model: select pins, enable pin, motion completion
`timescale 1ns/100ps
module select_host (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // bench requests
   input wire [3:0] selCode,
   input wire enReq,
   input wire [7:0] doneDelay,
   // sequencer side
   input wire profileStart,
   input wire discardRemaining,
   output reg profileSelectBit0,
   output reg profileSelectBit1,
   output reg profileSelectBit2,
   output reg profileSelectBit3,
   output reg sequencerEnableInput,
   output reg profileDone
);
   reg [7:0] doneCnt = 8'h00; // cycles left in current move
   initial {profileSelectBit3, profileSelectBit2, profileSelectBit1, profileSelectBit0,
      sequencerEnableInput, profileDone} = 6'h00;
   // pins follow requests just after the edge; 1 means active
   always @(posedge sys_clk) begin
      {profileSelectBit3, profileSelectBit2, profileSelectBit1, profileSelectBit0} <= selCode;
      sequencerEnableInput <= enReq;
      profileDone <= 1'b0;
      // a discarded move never completes
      if (rst || discardRemaining) begin
         doneCnt <= 8'h00;
      end else if (profileStart) begin
         doneCnt <= doneDelay;
      end else if (doneCnt != 8'h00) begin
         doneCnt <= doneCnt - 8'h01;
         profileDone <= doneCnt == 8'h01;
      end
   end
endmodule // select_host

// ---- verification/multi_position_sequencer_bench.sv ----
// self-checking bench for the multi-position sequencer
`timescale 1ns/100ps
module multi_position_sequencer_bench;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg [3:0] regAddr = 4'h0;
   reg [31:0] regWrData = 32'h0;
   reg regWrite = 1'b0;
   reg regRead = 1'b0;
   reg [3:0] selCode = 4'h0; // host select request
   reg enReq = 1'b1; // host enable request
   reg [7:0] doneDelay = 8'h14; // move length in cycles
   wire [31:0] regRdData, profileDisp;
   wire [15:0] profileSpeed, profileAccel;
   wire [4:0] activeProfile;
   wire profileSelectBit0, profileSelectBit1, profileSelectBit2, profileSelectBit3;
   wire sequencerEnableInput, profileDone, profileStart, discardRemaining, running, paused;
   int miscompares = 0;
   int totalChecks = 0;
   int i;
   always #10 sys_clk = ~sys_clk;
   multi_position_sequencer u_dut (.sys_clk, .rst, .regAddr, .regWrData, .regWrite,
      .regRead, .regRdData, .profileSelectBit0, .profileSelectBit1, .profileSelectBit2,
      .profileSelectBit3, .sequencerEnableInput, .profileDone, .profileStart,
      .discardRemaining, .profileDisp, .profileSpeed, .profileAccel, .running, .paused,
      .activeProfile);
   select_host u_host (.sys_clk, .rst, .selCode, .enReq, .doneDelay, .profileStart,
      .discardRemaining, .profileSelectBit0, .profileSelectBit1, .profileSelectBit2,
      .profileSelectBit3, .sequencerEnableInput, .profileDone);
   // verdict and end of run
   task testDone;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task check(input string name, input [31:0] seen, input [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one-cycle write strobe
   task wr(input [3:0] a, input [31:0] d);
      @(posedge sys_clk);
      {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task rd(input [3:0] a, input [31:0] exp);
      @(posedge sys_clk);
      {regAddr, regRead} <= {a, 1'b1};
      @(posedge sys_clk);
      regRead <= 1'b0;
      @(negedge sys_clk);
      check("regRdData", regRdData, exp);
   endtask
   // bounded wait: 0 start, 1 discard, 2 stopped
   task wt(input [1:0] w);
      int n;
      for (n = 0; n < 300; n++) begin
         @(negedge sys_clk);
         if ((w == 0 && profileStart === 1'b1) || (w == 1 && discardRemaining === 1'b1)
            || (w == 2 && running === 1'b0)) break;
      end
      if (n == 300) begin
         check("wait", 32'h0, 32'h1);
         testDone;
      end
   endtask
   task st(input [4:0] p);
      wt(0);
      check("activeProfile", activeProfile, p);
   endtask
   // pause through the enable pin
   task drop;
      @(posedge sys_clk);
      enReq <= 1'b0;
      wt(1);
      check("paused", paused, 32'h1);
   endtask
   task tRegs;
      rd(4'h0, 32'h1);
      rd(4'h1, 32'h1);
      rd(4'h2, 32'h0);
      rd(4'h3, 32'h0);
      rd(4'h7, 32'h0); // unmapped reads as zero
      for (i = 0; i < 4; i++) begin
         wr(4'h0, i);
         rd(4'h0, i);
      end
      wr(4'h0, 32'h1);
      wr(4'h1, 32'h0);
      rd(4'h1, 32'h1);
      wr(4'h1, 32'h14);
      rd(4'h1, 32'h10);
      wr(4'h4, 32'h5);
      repeat (10) @(negedge sys_clk);
      check("running", running, 32'h0);
      $display("done registers");
   endtask
   task tCyclic;
      for (i = 0; i < 3; i++) begin
         wr(4'h9, 32'h1000 + i);
         wr(4'hA, 32'h20 + i);
         wr(4'hB, 32'h30 + i);
         wr(4'h8, i);
      end
      wr(4'h1, 32'h3);
      wr(4'h3, 32'h2);
      wr(4'h4, 32'h5);
      for (i = 0; i < 4; i++) begin
         st(i % 3 + 1);
         check("profileDisp", profileDisp, 32'h1000 + i % 3);
         check("profileSpeed", profileSpeed, 32'h20 + i % 3);
         check("profileAccel", profileAccel, 32'h30 + i % 3);
      end
      wr(4'h1, 32'h7);
      rd(4'h1, 32'h3);
      $display("done cyclic");
   endtask
   task tPause;
      drop;
      @(posedge sys_clk);
      enReq <= 1'b1;
      st(2);
      drop;
      wr(4'h2, 32'h1);
      rd(4'h2, 32'h1);
      @(posedge sys_clk);
      enReq <= 1'b1;
      st(1);
      $display("done pause");
   endtask
   task tSelect;
      drop;
      wr(4'h0, 32'h2);
      @(posedge sys_clk);
      {selCode, enReq} <= {4'hF, 1'b1};
      st(16);
      @(posedge sys_clk);
      selCode <= 4'h0;
      st(1);
      @(posedge sys_clk);
      selCode <= 4'h5;
      st(6);
      $display("done select");
   endtask
   task tSingle;
      wr(4'h4, 32'h3);
      wt(1);
      wr(4'h0, 32'h0);
      doneDelay <= 8'h28;
      wr(4'h4, 32'h1);
      for (i = 1; i < 4; i++) st(i);
      wt(2);
      check("running", running, 32'h0);
      $display("done single");
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      tRegs;
      tCyclic;
      tPause;
      tSelect;
      tSingle;
      testDone;
   end
endmodule // multi_position_sequencer_bench
